/* File: shared/sdram_bp_consts.svh */
// Constants of the burst page SDRAM sequencer and its address multiplexer.
// Assumes inclusion by bare name from the design modules.
`ifndef SDRAM_BP_CONSTS_SVH
`define SDRAM_BP_CONSTS_SVH

// Timing basis
`define CLK_MHZ     100
`define TRAS_NS     48
`define TRP_NS      20
`define TMR_W       8

// Memory address lines and the line that carries precharge-all
`define MEM_AW      23
`define CMD_LINE    10

// Column count limits served by the multiplexer
`define COL_MIN     4'h8
`define COL_MAX     4'hd

// Read latency pipe depth
`define RD_PIPE_W   5

// Beat byte steps within a 16-byte line
`define STEP_16     4'h2
`define STEP_32     4'h4

`endif

/* File: shared/sdram_bp_pkg.sv */
// Types shared by the burst page SDRAM sequencer.
// Assumes the constants header sits beside it.
package sdram_bp_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_RCD   = 3'h1,
		ST_XFER  = 3'h2,
		ST_DRAIN = 3'h3,
		ST_RAS   = 3'h4,
		ST_RP    = 3'h5
	} state_t;

	// Memory commands as {row strobe, column strobe, write enable}, low active
	typedef enum logic [2:0] {
		CMD_NOP  = 3'h7,
		CMD_ACT  = 3'h3,
		CMD_RD   = 3'h5,
		CMD_WR   = 3'h4,
		CMD_PRECHARGE_ALL_CMD = 3'h2
	} cmd_t;

	// Transfer sizes
	typedef enum logic [1:0] {
		SZ_1B  = 2'h0,
		SZ_2B  = 2'h1,
		SZ_4B  = 2'h2,
		SZ_16B = 2'h3
	} size_t;

endpackage : sdram_bp_pkg

/* File: hdl/sdram_addr_mux.sv */
// Row/column address multiplexer for 16-bit and 32-bit ports.
// Assumes a static column count of 8 to 13 lines for the block in use.
`timescale 1ns/1ns
`default_nettype none
`include "sdram_bp_consts.svh"

module sdram_addr_mux #(
	parameter int AW = `MEM_AW
) (
	// Internal address and selection
	input  wire logic [31:0]   i_addr,
	input  wire logic          i_port_32,
	input  wire logic [3:0]    i_col_lines,
	input  wire logic          i_col_phase,
	// Memory address lines
	output logic      [AW-1:0] o_mem_addr
);

	if (AW < 13) begin : g_chk
		$error("sdram_addr_mux: AW below 13");
	end

	// Low field, interleaved field, then straight field of the map
	function automatic logic [AW-1:0] mux_map(input logic [31:0] a, input logic p32,
		input logic [3:0] cols, input logic col);
		logic [AW-1:0] m;
		int            lo;
		int            n;
		int            s;
		int            k;
		int            b;
		m  = '0;
		lo = p32 ? 7 : 8;
		n  = int'(cols) - lo;
		if (n < 0)
			n = 0;
		s  = p32 ? (col ? 16 : 17) : (col ? 17 : 18);
		for (int i = 0; i < AW; i++) begin
			k = i - lo;
			if (i < lo)
				b = col ? (p32 ? 2 : 1) + i : (p32 ? 15 : 16) - i;
			else if (k < n)
				b = s + 2 * k;
			else
				b = col ? 32 : s + n - 1 + k;
			m[i] = (b < 32) ? a[b[4:0]] : 1'b0;
		end
		return m;
	endfunction : mux_map

	// Map picked by port width and column count
	assign o_mem_addr = mux_map(i_addr, i_port_32, i_col_lines, i_col_phase);

endmodule : sdram_addr_mux
`default_nettype wire

/* File: hdl/sdram_beat_timer.sv */
// Loadable down-counter that paces memory command spacing.
// Assumes a synchronised active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "sdram_bp_consts.svh"

module sdram_beat_timer #(
	parameter int W = `TMR_W
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// Load and status
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_value,
	output logic              o_zero,
	output logic              o_near
);

	logic [W-1:0] count_r;

	// Count down to zero and hold there
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			count_r <= '0;
		else if (i_load)
			count_r <= i_value;
		else if (count_r != '0)
			count_r <= count_r - W'(1);
	end

	// Expired now, or expiring at the next edge
	assign o_zero = (count_r == '0);
	assign o_near = (count_r <= W'(1));

	chk_timer_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_load |=> count_r == $past(i_value)) else $error("timer did not load");

endmodule : sdram_beat_timer
`default_nettype wire

/* File: hdl/sdram_burst_page.sv */
// Burst page SDRAM sequencer: one activate, per-beat commands, precharge-all.
// Assumes static configuration inputs and memory read data sampled on i_clk.
`timescale 1ns/1ns
`default_nettype none
`include "sdram_bp_consts.svh"

module sdram_burst_page #(
	parameter int AW     = `MEM_AW,
	parameter int TRAS_NS = `TRAS_NS,
	parameter int TRP_NS  = `TRP_NS
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	// Bus request
	input  wire logic          i_req,
	input  wire logic          i_write,
	input  wire logic [31:0]   i_addr,
	input  wire logic [1:0]    i_size,
	input  wire logic [31:0]   i_wdata,
	output logic               o_ready,
	output logic               o_wdata_take,
	output logic [31:0]        o_rdata,
	output logic               o_rvalid,
	output logic               o_done,
	// Block configuration
	input  wire logic          i_port_32,
	input  wire logic [3:0]    i_col_lines,
	input  wire logic [1:0]    i_column_latency_field,
	// Memory pins
	output logic               o_row_strobe_n,
	output logic               o_column_strobe_n,
	output logic               o_write_en_n,
	output logic [AW-1:0]      o_addr,
	output logic [31:0]        o_dq_out,
	output logic               o_dq_oe,
	input  wire logic [31:0]   i_dq
);

	localparam int TW       = `TMR_W;
	localparam int TRAS_CYC = (TRAS_NS * `CLK_MHZ + 999) / 1000;
	localparam int TRP_CYC  = (TRP_NS * `CLK_MHZ + 999) / 1000;
	localparam int PW       = `RD_PIPE_W;

	if (TRAS_CYC < 1 || TRAS_CYC > 255 || TRP_CYC < 1 || TRP_CYC > 255) begin : g_chk
		$error("sdram_burst_page: timing counts out of range");
	end

	// Beats needed for a transfer size on a port width
	function automatic logic [3:0] beats_of(input logic [1:0] sz, input logic p32);
		logic [3:0] n;
		n = 4'h1;
		if (sz == sdram_bp_pkg::SZ_16B)
			n = p32 ? 4'h4 : 4'h8;
		else if (sz == sdram_bp_pkg::SZ_4B && !p32)
			n = 4'h2;
		return n;
	endfunction : beats_of

	// Reset release through two flip-flops
	logic rst_s1_r;
	logic rst_n;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			{rst_n, rst_s1_r} <= 2'b00;
		else
			{rst_n, rst_s1_r} <= {rst_s1_r, 1'b1};
	end

	// State and request hold
	sdram_bp_pkg::state_t state_r;
	sdram_bp_pkg::state_t state_nxt;
	sdram_bp_pkg::cmd_t   cmd_nxt;
	logic                 pend_r;
	logic                 wr_r;
	logic [31:0]          cur_r;
	logic [3:0]           beats_left_r;
	logic [3:0]           rd_left_r;
	logic                 p32_r;
	logic [3:0]           cols_r;
	logic [2:0]           lat_r;
	logic [PW-1:0]        rd_pipe_r;
	logic                 pin_last_r;
	// Timer controls and status
	logic          rcd_near;
	logic          ras_zero;
	logic          rp_zero;
	logic          act_go;
	logic          precharge_all_cmd_go;
	logic [TW-1:0] rcd_value;
	// Request acceptance; a cycle may arrive during the precharge delay
	wire take    = i_req && o_ready;
	assign o_ready = rst_n && !pend_r && (state_r == sdram_bp_pkg::ST_IDLE ||
		state_r == sdram_bp_pkg::ST_RP);
	// Activate only once the precharge-to-activate delay has run out
	assign act_go = pend_r && (state_r == sdram_bp_pkg::ST_IDLE ||
		(state_r == sdram_bp_pkg::ST_RP && rp_zero));

	// Read data tap at the column latency after each read
	wire rd_tap  = rd_pipe_r[lat_r];
	wire rd_last = rd_tap && (rd_left_r == 4'h1);
	wire last_beat = (beats_left_r == 4'h1);
	wire in_xfer   = (state_r == sdram_bp_pkg::ST_XFER);

	// Precharge-all once the page may close
	assign precharge_all_cmd_go = ras_zero && (state_r == sdram_bp_pkg::ST_RAS ||
		(state_r == sdram_bp_pkg::ST_DRAIN && rd_last));
	assign rcd_value = TW'(lat_r - 3'h1);

	// Next state and next command
	always_comb begin
		state_nxt = state_r;
		cmd_nxt   = sdram_bp_pkg::CMD_NOP;
		unique case (state_r)
			sdram_bp_pkg::ST_IDLE, sdram_bp_pkg::ST_RP: begin
				if (act_go) begin
					cmd_nxt   = sdram_bp_pkg::CMD_ACT;
					// Latency 1 goes straight to the column command
					state_nxt = (lat_r == 3'h1) ? sdram_bp_pkg::ST_XFER :
						sdram_bp_pkg::ST_RCD;
				end else if (state_r == sdram_bp_pkg::ST_RP && rp_zero) begin
					state_nxt = sdram_bp_pkg::ST_IDLE;
				end
			end
			sdram_bp_pkg::ST_RCD: begin
				// No-operations cover the row-to-column delay
				if (rcd_near)
					state_nxt = sdram_bp_pkg::ST_XFER;
			end
			sdram_bp_pkg::ST_XFER: begin
				// One column command per clock, no activate between
				cmd_nxt = wr_r ? sdram_bp_pkg::CMD_WR : sdram_bp_pkg::CMD_RD;
				if (last_beat)
					state_nxt = wr_r ? sdram_bp_pkg::ST_RAS : sdram_bp_pkg::ST_DRAIN;
			end
			sdram_bp_pkg::ST_DRAIN: begin
				// No-operations until the last read data
				if (rd_last) begin
					if (ras_zero) begin
						cmd_nxt   = sdram_bp_pkg::CMD_PRECHARGE_ALL_CMD;
						state_nxt = sdram_bp_pkg::ST_RP;
					end else begin
						state_nxt = sdram_bp_pkg::ST_RAS;
					end
				end
			end
			sdram_bp_pkg::ST_RAS: begin
				// Hold the page open to the activate-to-precharge minimum
				if (ras_zero) begin
					cmd_nxt   = sdram_bp_pkg::CMD_PRECHARGE_ALL_CMD;
					state_nxt = sdram_bp_pkg::ST_RP;
				end
			end
			default: begin
				state_nxt = sdram_bp_pkg::ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			state_r <= sdram_bp_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Captured request and configuration
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 1'b0;
			wr_r   <= 1'b0;
			p32_r  <= 1'b0;
			cols_r <= `COL_MIN;
			lat_r  <= 3'h1;
		end else if (take) begin
			pend_r <= 1'b1;
			wr_r   <= i_write;
			p32_r  <= i_port_32;
			cols_r <= i_col_lines;
			lat_r  <= {1'b0, i_column_latency_field} + 3'h1;
		end else if (act_go) begin
			pend_r <= 1'b0;
		end
	end

	// Beat address stepped by the controller, wrapping in the line
	wire [3:0] step = p32_r ? `STEP_32 : `STEP_16;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_r        <= 32'h0;
			beats_left_r <= 4'h0;
			rd_left_r    <= 4'h0;
		end else if (take) begin
			cur_r        <= i_addr;
			beats_left_r <= beats_of(i_size, i_port_32);
			rd_left_r    <= i_write ? 4'h0 : beats_of(i_size, i_port_32);
		end else begin
			if (in_xfer) begin
				cur_r[3:0]   <= cur_r[3:0] + step;
				beats_left_r <= beats_left_r - 4'h1;
			end
			if (rd_tap && rd_left_r != 4'h0)
				rd_left_r <= rd_left_r - 4'h1;
		end
	end

	// Row address in the activate, column address per beat
	logic [AW-1:0] mux_addr;
	sdram_addr_mux #(
		.AW          (AW)
	) u_mux (
		.i_addr      (cur_r),
		.i_port_32   (p32_r),
		.i_col_lines (cols_r),
		.i_col_phase (in_xfer),
		.o_mem_addr  (mux_addr)
	);

	// Activate-to-column, activate-to-precharge and precharge-to-activate timers
	sdram_beat_timer #(.W(TW)) u_rcd (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_load  (act_go),
		.i_value (rcd_value),
		.o_zero  (),
		.o_near  (rcd_near)
	);

	sdram_beat_timer #(.W(TW)) u_ras (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_load  (act_go),
		.i_value (TW'(TRAS_CYC - 1)),
		.o_zero  (ras_zero),
		.o_near  ()
	);

	sdram_beat_timer #(.W(TW)) u_rp (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_load  (precharge_all_cmd_go),
		.i_value (TW'(TRP_CYC - 1)),
		.o_zero  (rp_zero),
		.o_near  ()
	);
	// Write data is fetched as the write command is chosen
	assign o_wdata_take = (cmd_nxt == sdram_bp_pkg::CMD_WR);

	// Registered memory pins; precharge-all raises the command line
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_row_strobe_n    <= 1'b1;
			o_column_strobe_n <= 1'b1;
			o_write_en_n      <= 1'b1;
			o_addr            <= '0;
			o_dq_out          <= 32'h0;
			o_dq_oe           <= 1'b0;
			pin_last_r        <= 1'b0;
		end else begin
			{o_row_strobe_n, o_column_strobe_n, o_write_en_n} <= cmd_nxt;
			o_addr <= mux_addr;
			if (cmd_nxt == sdram_bp_pkg::CMD_PRECHARGE_ALL_CMD)
				o_addr[`CMD_LINE] <= 1'b1;
			if (o_wdata_take)
				o_dq_out <= i_wdata;
			o_dq_oe    <= o_wdata_take;
			pin_last_r <= in_xfer && last_beat;
		end
	end

	// Read latency pipe and read data capture
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pipe_r <= '0;
			o_rdata   <= 32'h0;
			o_rvalid  <= 1'b0;
			o_done    <= 1'b0;
		end else begin
			rd_pipe_r <= {rd_pipe_r[PW-2:0], (cmd_nxt == sdram_bp_pkg::CMD_RD)};
			o_rvalid  <= rd_tap;
			if (rd_tap)
				o_rdata <= i_dq;
			o_done    <= precharge_all_cmd_go;
		end
	end

	// Pin command decode and activate age, used only by the checks below
	wire pin_act  = !o_row_strobe_n && o_column_strobe_n && o_write_en_n;
	wire pin_rw   = o_row_strobe_n && !o_column_strobe_n;
	wire pin_wr   = pin_rw && !o_write_en_n;
	wire pin_precharge_all_cmd = !o_row_strobe_n && o_column_strobe_n && !o_write_en_n;
	wire pin_nop  = o_row_strobe_n && o_column_strobe_n && o_write_en_n;
	logic [TW-1:0] since_act_r;
	logic          page_shut_r;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			since_act_r <= '0;
		else if (pin_act)
			since_act_r <= TW'(1);
		else if (since_act_r != '1)
			since_act_r <= since_act_r + TW'(1);
	end
	// Page state seen on the pins: shut after precharge-all, open after activate
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			page_shut_r <= 1'b1;
		else if (pin_act || pin_precharge_all_cmd)
			page_shut_r <= pin_precharge_all_cmd;
	end

	chk_act_then_rw: assert property (@(posedge i_clk) disable iff (!rst_n)
		pin_act |-> ##[1:4] pin_rw) else $error("no column command after activate");
	chk_lat1_no_nop: assert property (@(posedge i_clk) disable iff (!rst_n)
		(pin_act && lat_r == 3'h1) |=> pin_rw) else $error("gap after activate");
	chk_rcd_two: assert property (@(posedge i_clk) disable iff (!rst_n)
		(pin_act && lat_r == 3'h2) |=> pin_nop ##1 pin_rw) else $error("tRCD not 2");
	chk_beat_each_clk: assert property (@(posedge i_clk) disable iff (!rst_n)
		(pin_rw && !pin_last_r) |=> pin_rw) else $error("beat gap in page");
	chk_one_activate: assert property (@(posedge i_clk) disable iff (!rst_n)
		pin_act |-> page_shut_r) else $error("second activate in an open page");
	chk_addr_step: assert property (@(posedge i_clk) disable iff (!rst_n)
		(pin_rw && $past(pin_rw)) |-> o_addr != $past(o_addr)) else $error("addr stuck");
	chk_read_precharge_all_cmd: assert property (@(posedge i_clk) disable iff (!rst_n)
		(state_r == sdram_bp_pkg::ST_DRAIN && rd_last && ras_zero) |=> pin_precharge_all_cmd)
		else $error("precharge not after last read");
	chk_ras_min: assert property (@(posedge i_clk) disable iff (!rst_n)
		pin_precharge_all_cmd |-> since_act_r >= TW'(TRAS_CYC)) else $error("tRAS violated");
	chk_rp_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
		pin_precharge_all_cmd |=> !pin_act) else $error("activate inside precharge delay");
	chk_wr_data: assert property (@(posedge i_clk) disable iff (!rst_n)
		pin_wr |-> o_dq_oe) else $error("write data not driven");
	chk_precharge_all_cmd_line: assert property (@(posedge i_clk) disable iff (!rst_n)
		pin_precharge_all_cmd |-> o_addr[`CMD_LINE]) else $error("command line low on precharge");
endmodule : sdram_burst_page
`default_nettype wire

/* File: verif/sdram_model.sv */
// Behavioural memory on the far side of the burst page sequencer.
// Assumes registered command pins on i_clk and a read latency given in cycles.
`timescale 1ns/1ns
`default_nettype none

module sdram_model (
	// Clock and command pins
	input  wire logic        i_clk,
	input  wire logic        i_row_strobe_n,
	input  wire logic        i_column_strobe_n,
	input  wire logic        i_write_en_n,
	input  wire logic [2:0]  i_lat,
	// Read data towards the controller
	output logic      [31:0] o_dq
);
	logic [3:0]  rd_v  = 4'h0;
	logic [31:0] rd_d  [4];
	logic [31:0] n_rd  = 32'h0;
	logic [31:0] noise = 32'h0;
	wire         is_rd = (i_row_strobe_n === 1'b1) && (i_column_strobe_n === 1'b0)
	                     && (i_write_en_n === 1'b1);

	// One word per read command, no internal burst counter
	always @(posedge i_clk) begin
		rd_v    <= {rd_v[2:0], is_rd};
		rd_d[0] <= 32'hd0000000 + n_rd;
		rd_d[1] <= rd_d[0];
		rd_d[2] <= rd_d[1];
		rd_d[3] <= rd_d[2];
		n_rd    <= n_rd + {31'h0, is_rd};
		noise   <= ~noise; // Idle bus changes every cycle
	end

	// Data stands only in the cycle that is latency cycles after the read
	assign o_dq = rd_v[i_lat - 3'h1] ? rd_d[i_lat - 3'h1] : noise;
endmodule : sdram_model

`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the burst page sequencer and its address maps.
// Assumes the memory model beside it and default timing parameters.
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic        clk, rst_n, req, wr, p32, ready, take, rvalid, done, row_n, col_n, we_n, dq_oe;
	logic [31:0] adr, wdata, rdata, dq_out, dq;
	logic [1:0]  size, latf;
	logic [3:0]  cols;
	logic [22:0] maddr;
	int          n_fail, n_tests, cyc, n_rd, n_wexp, n_wsent, precharge_all_cmd_cyc;
	logic [2:0]  q_cmd[$];
	logic [22:0] q_adr[$];
	logic [31:0] q_rexp[$];
	int          q_cyc[$], q_rcyc[$];
	wire  [2:0]  cmd = {row_n, col_n, we_n};

	sdram_burst_page i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_write(wr),
		.i_addr(adr), .i_size(size), .i_wdata(wdata), .o_ready(ready), .o_wdata_take(take),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_done(done), .i_port_32(p32), .i_col_lines(cols),
		.i_column_latency_field(latf), .o_row_strobe_n(row_n), .o_column_strobe_n(col_n),
		.o_write_en_n(we_n), .o_addr(maddr), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq(dq));
	sdram_model i_mem (.i_clk(clk), .i_row_strobe_n(row_n), .i_column_strobe_n(col_n),
		.i_write_en_n(we_n), .i_lat({1'b0, latf} + 3'h1), .o_dq(dq));

	// Single compare for every kind of result
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (exp !== got) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	// Expected address lines as {mask, value}, worked out from the map tables
	function automatic logic [45:0] amap(input logic p, input logic [3:0] n, input logic c,
		input logic [31:0] a);
		logic [22:0] v, m;
		int          i, b, k;
		v = '0;
		m = '0;
		k = int'(n) - 8;
		for (i = 0; i < 23; i++) begin
			if (p && c)
				b = (i < 7) ? i + 2 : (i == 7) ? 16 : (i < 8 + k) ? 2 * i + 2 : -1;
			else if (p)
				b = (i < 7) ? 15 - i : (i == 7) ? 17 : (i < 8 + k) ? 2 * i + 3 : i + 10 + k;
			else if (c)
				b = (i < 8) ? i + 1 : (i < 8 + k) ? 2 * i + 1 : -1;
			else
				b = (i < 8) ? 16 - i : (i < 8 + k) ? 2 * i + 2 : i + 9 + k;
			if (b >= 0 && b < 32) begin
				v[i] = a[b];
				m[i] = 1'b1;
			end
		end
		return {m, v};
	endfunction : amap

	// One whole transfer: request held until taken, then wait for completion
	task automatic xfer(input logic w, input logic [31:0] a, input logic [1:0] s,
		input logic p, input logic [3:0] n, input logic [1:0] lf);
		int k;
		@(posedge clk);
		q_cmd.delete();
		q_adr.delete();
		q_cyc.delete();
		req <= 1'b1;
		wr <= w;
		adr <= a;
		size <= s;
		p32 <= p;
		cols <= n;
		latf <= lf;
		k = 0;
		@(negedge clk);
		while (ready !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		@(posedge clk);
		req <= 1'b0;
		@(negedge clk);
		chk("ready after take", 0, ready);
		k = 0;
		while (done !== 1'b1 && k < 200) begin
			@(negedge clk);
			k++;
		end
		chk("done pulse", 1, done);
		@(negedge clk);
	endtask : xfer

	// Row and column maps of 16-bit ports at 11 to 13 columns and 32-bit ports at 8 to 12, with tRP spacing
	task automatic s_maps();
		logic [45:0] r, c;
		logic [31:0] a;
		logic        p;
		logic [3:0]  n;
		int          i, pc;
		for (i = 0; i < 8; i++) begin
			p = (i > 2);
			n = p ? 4'h8 + 4'(i - 3) : 4'hb + 4'(i);
			a = 32'h9e5ac3a4 ^ (32'(i) * 32'h01111000);
			pc = precharge_all_cmd_cyc;
			xfer(1'b0, a, sdram_bp_pkg::SZ_4B, p, n, 2'h1);
			r = amap(p, n, 1'b0, a);
			c = amap(p, n, 1'b1, a);
			chk("act cmd", sdram_bp_pkg::CMD_ACT, q_cmd[0]);
			chk("row map", r[22:0], q_adr[0] & r[45:23]);
			chk("col map", c[22:0], q_adr[1] & c[45:23]);
			chk("rw count", p ? 1 : 2, q_cmd.size() - 2);
			chk("precharge gap", 1, (q_cyc[0] - pc) >= 2);
			if (!p) begin
				c = amap(p, n, 1'b1, a + 32'h2);
				chk("col map beat2", c[22:0], q_adr[2] & c[45:23]);
			end
		end
	endtask : s_maps

	// Shared judgement of a 16-byte burst on the 32-bit port starting at offset 8
	task automatic burst_check(input logic w, input int tail, output int len);
		logic [45:0] c;
		int          k;
		chk("cmd count", 6, q_cmd.size());
		chk("act first", sdram_bp_pkg::CMD_ACT, q_cmd[0]);
		chk("act to col", 2, q_cyc[1] - q_cyc[0]);
		for (k = 1; k < 5; k++) begin
			c = amap(1'b1, 4'h8, 1'b1, {28'h0012345, 4'(8 + 4 * (k - 1))});
			chk("beat cmd", w ? sdram_bp_pkg::CMD_WR : sdram_bp_pkg::CMD_RD, q_cmd[k]);
			chk("beat cycle", q_cyc[1] + k - 1, q_cyc[k]);
			chk("beat addr", c[22:0], q_adr[k] & c[45:23]);
		end
		chk("precharge_all_cmd last", sdram_bp_pkg::CMD_PRECHARGE_ALL_CMD, q_cmd[5]);
		chk("precharge_all_cmd cycle", q_cyc[4] + tail, q_cyc[5]);
		len = q_cyc[5] - q_cyc[0];
	endtask : burst_check

	// Read burst, then a write burst that must close two cycles sooner
	task automatic s_bursts();
		int rl, wl;
		xfer(1'b0, 32'h00123458, sdram_bp_pkg::SZ_16B, 1'b1, 4'h8, 2'h1);
		burst_check(1'b0, 3, rl);
		xfer(1'b1, 32'h00123458, sdram_bp_pkg::SZ_16B, 1'b1, 4'h8, 2'h1);
		burst_check(1'b1, 1, wl);
		chk("write shorter", rl - 2, wl);
	endtask : s_bursts

	// Latency one: no gap after activate, and tRAS (5 cycles) holds off precharge
	task automatic s_short();
		xfer(1'b1, 32'h00000100, sdram_bp_pkg::SZ_4B, 1'b1, 4'h9, 2'h0);
		chk("no nop gap", 1, q_cyc[1] - q_cyc[0]);
		chk("act to precharge_all_cmd", 5, q_cyc[2] - q_cyc[0]);
	endtask : s_short

	// Longest and middle latencies: 16-bit line burst read, then a short write
	task automatic s_lat();
		logic [45:0] c;
		xfer(1'b0, 32'h0000a00e, sdram_bp_pkg::SZ_16B, 1'b0, 4'hb, 2'h3);
		c = amap(1'b0, 4'hb, 1'b1, 32'h0000a00c);
		chk("beats 16b", 10, q_cmd.size());
		chk("act to col lat4", 4, q_cyc[1] - q_cyc[0]);
		chk("last beat addr", c[22:0], q_adr[8] & c[45:23]);
		chk("precharge_all_cmd after data", q_cyc[8] + 5, q_cyc[9]);
		xfer(1'b1, 32'h00000202, sdram_bp_pkg::SZ_2B, 1'b0, 4'hc, 2'h2);
		chk("act to col lat3", 3, q_cyc[1] - q_cyc[0]);
		chk("act to precharge_all_cmd lat3", 5, q_cyc[2] - q_cyc[0]);
	endtask : s_lat

	// Pin monitor: commands, write data and read data in order
	always @(negedge clk) begin
		cyc = cyc + 1;
		if (rst_n === 1'b1 && cmd !== sdram_bp_pkg::CMD_NOP) begin
			q_cmd.push_back(cmd);
			q_adr.push_back(maddr);
			q_cyc.push_back(cyc);
		end
		if (cmd === sdram_bp_pkg::CMD_RD) begin
			q_rexp.push_back(32'hd0000000 + 32'(n_rd));
			q_rcyc.push_back(cyc + int'(latf) + 2);
			n_rd++;
		end
		if (cmd === sdram_bp_pkg::CMD_WR) begin
			chk("write oe", 1, dq_oe);
			chk("write data", 32'hc0de0000 + 32'(n_wexp), dq_out);
			n_wexp++;
		end
		if (cmd === sdram_bp_pkg::CMD_PRECHARGE_ALL_CMD) begin
			precharge_all_cmd_cyc = cyc;
			chk("precharge_all_cmd line 10", 1, maddr[10]);
		end
		if (rvalid === 1'b1 && q_rexp.size() > 0) begin
			chk("read data", q_rexp.pop_front(), rdata);
			chk("read cycle", q_rcyc.pop_front(), cyc);
		end else if (rvalid === 1'b1)
			chk("stray rvalid", 0, 1);
	end

	// Write data for the next beat follows each take pulse
	always @(posedge clk) begin
		if (take === 1'b1) begin
			n_wsent <= n_wsent + 1;
			wdata <= 32'hc0de0001 + 32'(n_wsent);
		end
	end

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{rst_n, req, wr, p32} = 4'h0;
		{adr, size, cols, latf} = '0;
		wdata = 32'hc0de0000;
		{n_fail, n_tests, cyc, n_rd, n_wexp, n_wsent} = '0;
		precharge_all_cmd_cyc = -100;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("ready in reset", 0, ready);
		repeat (3) @(posedge clk);
		s_maps();
		s_bursts();
		s_short();
		s_lat();
		repeat (10) @(posedge clk);
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
